// [v86pc_pkg.sv]
// Constants, register map, operation codes and carrier structs for the
// virtual-8086 protection check unit.
// Assumes one 250 MHz clock and a core that presents one decoded request
// per cycle and applies the answer that comes back one cycle later.
package v86pc_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [4:0]  OFF_CTRL   = 5'h00;
  localparam logic [4:0]  OFF_FLAGS  = 5'h04;
  localparam logic [4:0]  OFF_PDB    = 5'h08;
  localparam logic [4:0]  OFF_IOMAP  = 5'h0c;
  localparam logic [4:0]  OFF_STATUS = 5'h10;
  localparam logic [4:0]  OFF_PAGE   = 5'h14;
  localparam logic [4:0]  OFF_TSSB   = 5'h18;

  // Field positions.
  localparam int unsigned CTRL_PE    = 0;
  localparam int unsigned CTRL_PG    = 1;
  localparam int unsigned CTRL_CPL   = 2;
  localparam int unsigned FL_TF      = 8;
  localparam int unsigned FL_IF      = 9;
  localparam int unsigned FL_IO_PRIVILEGE_LEVEL    = 12;
  localparam int unsigned FL_VM      = 17;
  localparam int unsigned ST_FAULT   = 8;
  localparam int unsigned ST_VM      = 9;
  localparam int unsigned SEG_SHIFT  = 4;
  localparam int unsigned PAGE_SHIFT = 12;

  // Values after reset.
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
  localparam logic [31:0] PDB_RST   = 32'h0000_0000;
  localparam logic [31:0] IOMAP_RST = 32'h0000_0000;

  // Masks, vectors, levels, descriptor types and bus answers.
  localparam logic [31:0] VM_MASK   = 32'h0002_0000;
  localparam logic [31:0] EXIT_MASK = 32'h0002_0300;
  localparam logic [7:0]  VEC_GP    = 8'h0d;
  localparam logic [7:0]  VEC_UD    = 8'h06;
  localparam logic [1:0]  PL_KERNEL = 2'h0;
  localparam logic [1:0]  PL_USER   = 2'h3;
  localparam logic [3:0]  TSS_FULL  = 4'h9;
  localparam logic [3:0]  TSS_FULLB = 4'hb;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_PRIV = 4'h1, OP_PMONLY = 4'h2, OP_IO = 4'h3,
    OP_CLI = 4'h4, OP_STI = 4'h5, OP_INTN = 4'h6, OP_INTU = 4'h7,
    OP_PUSHF = 4'h8, OP_POPF = 4'h9, OP_IRET = 4'ha, OP_TSWITCH = 4'hb,
    OP_EVENT = 4'hc, OP_MEM = 4'hd
  } v86pc_op_e;

  // One decoded request from the core.
  typedef struct packed {
    v86pc_op_e   op;
    logic [15:0] port;
    logic [2:0]  size;
    logic        op32;
    logic [31:0] data;
    logic [31:0] cr3;
    logic [3:0]  tss_type;
    logic [1:0]  tss_cpl;
    logic        gate_conf;
    logic [1:0]  gate_dpl;
    logic [15:0] gate_sel;
    logic [15:0] seg;
    logic [15:0] offset;
  } v86pc_req_s;

  // The answer, one cycle after the request.
  typedef struct packed {
    logic        fault;
    logic [7:0]  vector;
    logic [15:0] err;
    logic [31:0] data;
    logic        seg_8086;
    logic [23:0] phys;
  } v86pc_rsp_s;

endpackage

// [v86pc_checks.sv]
// Virtual-8086 protection, I/O permission and mode control unit.
// Assumes the core sends one decoded request per cycle on req and applies
// rsp the cycle after; software configures it over AXI4-Lite.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
module v86pc_checks #(
  parameter int unsigned TSS_BYTES = 128,
  parameter int unsigned PAGES     = 256
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire logic [31:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [31:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 req_valid,
  input  wire v86pc_pkg::v86pc_req_s req,
  output logic                      req_ready,
  output logic                      rsp_valid,
  output v86pc_pkg::v86pc_rsp_s     rsp,
  output logic                      vm_active
);

  localparam int unsigned IDX_W = $clog2(TSS_BYTES);
  localparam int unsigned PG_W  = $clog2(PAGES);

  logic [31:0] ctrl;
  logic [31:0] flags;
  logic [31:0] pdbase;
  logic [31:0] iomap;
  logic        fault_seen;
  logic [7:0]  last_vec;
  logic [15:0] last_err;
  logic [7:0]  tss_mem [TSS_BYTES];
  logic [11:0] page_frame [PAGES];
  logic        aw_got;
  logic        w_got;
  logic [4:0]  waddr;
  logic        waddr_ok;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [31:0] next_ctrl;
  logic [31:0] next_flags;
  logic [31:0] next_pdbase;
  logic [31:0] rd_data;
  logic [31:0] out_data;
  logic        out_seg;
  logic        fault;
  logic [7:0]  vector;
  logic [15:0] err;
  logic        io_bits;

  // Merge written byte lanes into a register.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // An address is mapped when its high bits are zero and it hits a register.
  function automatic logic reg_hit(input logic [31:0] a);
    return (a[31:5] == 27'h0) && (a[4:0] <= v86pc_pkg::OFF_TSSB) && (a[1:0] == 2'h0);
  endfunction

  // Permission bit for one port; outside the map or the stored bytes it reads as one.
  function automatic logic perm_bit(input logic [15:0] p);
    logic [16:0] off;
    off = 17'(iomap[15:0]) + 17'(p[15:3]);
    if (off > 17'(iomap[31:16]) || off >= 17'(TSS_BYTES)) begin
      return 1'b1;
    end
    return tss_mem[off[IDX_W-1:0]][p[2:0]];
  endfunction

  // Mode decode. Virtual-mode code is forced to level 3; real mode acts as level 0.
  wire       pe      = ctrl[v86pc_pkg::CTRL_PE];
  wire       pg      = ctrl[v86pc_pkg::CTRL_PG];
  wire       vm      = flags[v86pc_pkg::FL_VM];
  wire [1:0] io_privilege_level    = flags[v86pc_pkg::FL_IO_PRIVILEGE_LEVEL +: 2];
  wire [1:0] cpl_eff = !pe ? v86pc_pkg::PL_KERNEL :
                       vm  ? v86pc_pkg::PL_USER : ctrl[v86pc_pkg::CTRL_CPL +: 2];
  wire       take    = req_valid;
  wire       ok      = take && !fault;
  wire       io_dir  = !pe || (!vm && (cpl_eff <= io_privilege_level));
  wire       io_privilege_level_v  = vm && (io_privilege_level != v86pc_pkg::PL_USER);
  wire       full_tss = (req.tss_type == v86pc_pkg::TSS_FULL) ||
                        (req.tss_type == v86pc_pkg::TSS_FULLB);
  wire       wr_fire = aw_got && w_got && !s_axi_bvalid;
  wire       wr_full = wr_fire && waddr_ok && (wstrb == 4'hf);

  // Real-mode style linear address, then the page frame lookup.
  wire [20:0] lin  = (21'(req.seg) << v86pc_pkg::SEG_SHIFT) + 21'(req.offset);
  wire [23:0] phys = pg ? {page_frame[lin[v86pc_pkg::PAGE_SHIFT +: PG_W]],
                           lin[v86pc_pkg::PAGE_SHIFT-1:0]} : {3'h0, lin};

  assign req_ready     = 1'b1;
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign vm_active     = vm;

  // Every byte port spanned by the access is tested, up to a doubleword.
  always_comb begin
    io_bits = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < req.size) begin
        io_bits = io_bits | perm_bit(req.port + 16'(i));
      end
    end
  end

  // Fault decision. It only sets fault, vector and error code; state is left for the update below.
  always_comb begin
    fault  = 1'b0;
    vector = 8'h00;
    err    = 16'h0000;
    unique case (req.op)
      v86pc_pkg::OP_PRIV: begin
        fault = vm || (cpl_eff != v86pc_pkg::PL_KERNEL);
      end
      v86pc_pkg::OP_PMONLY: begin
        fault  = !pe || vm;
        vector = v86pc_pkg::VEC_UD;
      end
      v86pc_pkg::OP_IO: begin
        fault = !io_dir && io_bits;
      end
      v86pc_pkg::OP_CLI, v86pc_pkg::OP_STI: begin
        fault = vm ? io_privilege_level_v : (pe && (cpl_eff > io_privilege_level));
      end
      v86pc_pkg::OP_INTN, v86pc_pkg::OP_PUSHF, v86pc_pkg::OP_POPF, v86pc_pkg::OP_IRET: begin
        fault = io_privilege_level_v;
      end
      v86pc_pkg::OP_EVENT: begin
        fault = vm && (req.gate_conf || (req.gate_dpl != v86pc_pkg::PL_KERNEL));
        err   = req.gate_sel;
      end
      v86pc_pkg::OP_MEM: begin
        fault = (vm || !pe) && lin[20];
      end
      default: begin
        fault = 1'b0;
      end
    endcase
    if (fault && (req.op != v86pc_pkg::OP_PMONLY)) begin
      vector = v86pc_pkg::VEC_GP;
    end
  end

  // Next architectural state: software writes first, a successful request overrides.
  always_comb begin
    next_ctrl   = ctrl;
    next_flags  = flags;
    next_pdbase = pdbase;
    out_data    = 32'h0000_0000;
    out_seg     = vm;
    if (wr_fire && waddr_ok) begin
      if (waddr == v86pc_pkg::OFF_CTRL) next_ctrl = merge(ctrl, wdata, wstrb);
      if (waddr == v86pc_pkg::OFF_FLAGS) next_flags = merge(flags, wdata, wstrb);
      if (waddr == v86pc_pkg::OFF_PDB) next_pdbase = merge(pdbase, wdata, wstrb);
    end
    if (ok) begin
      unique case (req.op)
        v86pc_pkg::OP_CLI: next_flags[v86pc_pkg::FL_IF] = 1'b0;
        v86pc_pkg::OP_STI: next_flags[v86pc_pkg::FL_IF] = 1'b1;
        v86pc_pkg::OP_PUSHF: out_data = flags & ~v86pc_pkg::VM_MASK;
        v86pc_pkg::OP_POPF: begin
          next_flags = (req.data & ~v86pc_pkg::VM_MASK) | (flags & v86pc_pkg::VM_MASK);
        end
        v86pc_pkg::OP_IRET: begin
          if (req.op32 && pe && !vm && cpl_eff == v86pc_pkg::PL_KERNEL) begin
            next_flags = req.data;
            if (req.data[v86pc_pkg::FL_VM]) begin
              next_ctrl[v86pc_pkg::CTRL_CPL +: 2] = v86pc_pkg::PL_USER;
            end
          end else begin
            next_flags = (req.data & ~v86pc_pkg::VM_MASK) | (flags & v86pc_pkg::VM_MASK);
          end
          out_seg = next_flags[v86pc_pkg::FL_VM];
        end
        v86pc_pkg::OP_TSWITCH: begin
          out_data    = flags;
          next_pdbase = req.cr3;
          if (full_tss) begin
            next_flags = req.data;
            next_ctrl[v86pc_pkg::CTRL_CPL +: 2] =
              req.data[v86pc_pkg::FL_VM] ? v86pc_pkg::PL_USER : req.tss_cpl;
          end else begin
            next_flags = {flags[31:16] & ~v86pc_pkg::VM_MASK[31:16], req.data[15:0]};
            next_ctrl[v86pc_pkg::CTRL_CPL +: 2] = req.tss_cpl;
          end
          out_seg = next_flags[v86pc_pkg::FL_VM];
        end
        v86pc_pkg::OP_EVENT: begin
          out_data   = flags;
          next_flags = flags & ~v86pc_pkg::EXIT_MASK;
          next_ctrl[v86pc_pkg::CTRL_CPL +: 2] = vm ? v86pc_pkg::PL_KERNEL : req.gate_dpl;
          out_seg    = 1'b0;
        end
        default: out_data = 32'h0000_0000;
      endcase
    end
  end

  // Architectural state and the answer to the core.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl      <= v86pc_pkg::CTRL_RST;
      flags     <= v86pc_pkg::FLAGS_RST;
      pdbase    <= v86pc_pkg::PDB_RST;
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      ctrl      <= next_ctrl;
      flags     <= next_flags;
      pdbase    <= next_pdbase;
      rsp_valid <= take;
      rsp       <= '{fault: fault, vector: vector, err: err, data: out_data,
                     seg_8086: out_seg, phys: phys};
    end
  end

  // Sticky fault record; a new fault wins over a software clear in the same cycle.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_seen <= 1'b0;
      last_vec   <= 8'h00;
      last_err   <= 16'h0000;
      iomap      <= v86pc_pkg::IOMAP_RST;
    end else begin
      if (take && fault) begin
        fault_seen <= 1'b1;
        last_vec   <= vector;
        last_err   <= err;
      end else if (wr_fire && waddr_ok && waddr == v86pc_pkg::OFF_STATUS && wstrb[1] &&
                   wdata[v86pc_pkg::ST_FAULT]) begin
        fault_seen <= 1'b0;
      end
      if (wr_fire && waddr_ok && waddr == v86pc_pkg::OFF_IOMAP) begin
        iomap <= merge(iomap, wdata, wstrb);
      end
    end
  end

  // Page frame table and stored segment bytes; full-word writes only.
  // The frame table resets to an identity map so that paging can be enabled early.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < PAGES; i++) page_frame[i] <= 12'(i);
      for (int i = 0; i < TSS_BYTES; i++) tss_mem[i] <= 8'hff;
    end else if (wr_full) begin
      if (waddr == v86pc_pkg::OFF_PAGE) page_frame[wdata[PG_W-1:0]] <= wdata[19:8];
      if (waddr == v86pc_pkg::OFF_TSSB && wdata[31:16] < 16'(TSS_BYTES)) begin
        tss_mem[wdata[IDX_W+15:16]] <= wdata[7:0];
      end
    end
  end

  // Write channel: address and data are taken in either order, then answered.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      waddr        <= 5'h00;
      waddr_ok     <= 1'b0;
      wdata        <= 32'h0000_0000;
      wstrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= v86pc_pkg::RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got   <= 1'b1;
        waddr    <= s_axi_awaddr[4:0];
        waddr_ok <= reg_hit(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wdata <= s_axi_wdata;
        wstrb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= waddr_ok ? v86pc_pkg::RESP_OK : v86pc_pkg::RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; write-only table ports read as zero.
  always_comb begin
    unique case (s_axi_araddr[4:0])
      v86pc_pkg::OFF_CTRL:   rd_data = ctrl;
      v86pc_pkg::OFF_FLAGS:  rd_data = flags;
      v86pc_pkg::OFF_PDB:    rd_data = pdbase;
      v86pc_pkg::OFF_IOMAP:  rd_data = iomap;
      v86pc_pkg::OFF_STATUS: rd_data = {last_err, 6'h00, vm, fault_seen, last_vec};
      default:               rd_data = 32'h0000_0000;
    endcase
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= v86pc_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= reg_hit(s_axi_araddr) ? rd_data : 32'h0000_0000;
      s_axi_rresp  <= reg_hit(s_axi_araddr) ? v86pc_pkg::RESP_OK : v86pc_pkg::RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the unit's own behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  wire sw_state = wr_fire && waddr_ok && (waddr <= v86pc_pkg::OFF_PDB);
  wire beyond   = (17'(iomap[15:0]) + 17'(req.port[15:3])) > 17'(iomap[31:16]);

  property p_priv_fault;
    take && req.op == v86pc_pkg::OP_PRIV && vm |=> rsp_valid && rsp.fault && rsp.vector == 8'h0d;
  endproperty
  a_priv_fault: assert property (p_priv_fault) else $error("privileged op not faulted");

  property p_pmonly_fault;
    take && req.op == v86pc_pkg::OP_PMONLY && !pe |=> rsp.fault && rsp.vector == 8'h06;
  endproperty
  a_pmonly_fault: assert property (p_pmonly_fault) else $error("protected-only op not 6");

  // Entry into the mode must leave the stored privilege at user level.
  property p_vm_level;
    take && ok && !vm && !sw_state &&
      (req.op == v86pc_pkg::OP_IRET || req.op == v86pc_pkg::OP_TSWITCH)
      |=> !vm || ctrl[v86pc_pkg::CTRL_CPL +: 2] == v86pc_pkg::PL_USER;
  endproperty
  a_vm_level: assert property (p_vm_level) else $error("virtual mode not at level 3");

  property p_fault_keeps;
    take && fault && !sw_state |=> flags == $past(flags) && ctrl == $past(ctrl);
  endproperty
  a_fault_keeps: assert property (p_fault_keeps) else $error("faulting op changed state");

  property p_pushf_zero;
    take && req.op == v86pc_pkg::OP_PUSHF && !fault |=> !rsp.data[v86pc_pkg::FL_VM];
  endproperty
  a_pushf_zero: assert property (p_pushf_zero) else $error("push stored virtual bit");

  property p_popf_keep;
    take && req.op == v86pc_pkg::OP_POPF && !sw_state |=> $stable(vm);
  endproperty
  a_popf_keep: assert property (p_popf_keep) else $error("pop changed virtual bit");

  property p_event_exit;
    take && req.op == v86pc_pkg::OP_EVENT && vm && !fault
      |=> !vm && rsp.data[v86pc_pkg::FL_VM] && ctrl[v86pc_pkg::CTRL_CPL +: 2] == 2'h0;
  endproperty
  a_event_exit: assert property (p_event_exit) else $error("event did not leave mode");

  property p_gate_bad;
    take && req.op == v86pc_pkg::OP_EVENT && vm && req.gate_conf && !sw_state
      |=> rsp.fault && rsp.err == $past(req.gate_sel) && vm;
  endproperty
  a_gate_bad: assert property (p_gate_bad) else $error("bad gate not faulted");

  property p_tswitch_pdb;
    take && req.op == v86pc_pkg::OP_TSWITCH |=> pdbase == $past(req.cr3);
  endproperty
  a_tswitch_pdb: assert property (p_tswitch_pdb) else $error("directory base not reloaded");

  property p_io_beyond;
    take && req.op == v86pc_pkg::OP_IO && pe && vm && beyond |=> rsp.fault;
  endproperty
  a_io_beyond: assert property (p_io_beyond) else $error("port beyond map allowed");

  property p_io_direct;
    take && req.op == v86pc_pkg::OP_IO && pe && !vm && cpl_eff <= io_privilege_level |=> !rsp.fault;
  endproperty
  a_io_direct: assert property (p_io_direct) else $error("privileged port access faulted");

  property p_iret_enter;
    take && req.op == v86pc_pkg::OP_IRET && req.op32 && pe && !vm && cpl_eff == 2'h0 &&
      req.data[v86pc_pkg::FL_VM] && !sw_state
      |=> vm && rsp.seg_8086 && ctrl[v86pc_pkg::CTRL_CPL +: 2] == v86pc_pkg::PL_USER;
  endproperty
  a_iret_enter: assert property (p_iret_enter) else $error("return did not enter mode");

  c_event_exit: cover property (take && req.op == v86pc_pkg::OP_EVENT && vm && !fault);
  c_iret_enter: cover property (take && req.op == v86pc_pkg::OP_IRET && !vm ##1 vm);
  c_io_fault:   cover property (take && req.op == v86pc_pkg::OP_IO && vm && fault);
  c_tsw_vm:     cover property (take && req.op == v86pc_pkg::OP_TSWITCH && full_tss ##1 vm);

endmodule

// [v86pc_tb.sv]
// Self-checking bench for the virtual-8086 protection check unit.
// Assumes the answer comes one cycle after each request and AXI4-Lite registers.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic [31:0]           s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [31:0]           s_axi_rdata, rd;
  logic [3:0]            s_axi_wstrb = 4'hf;
  logic [1:0]            s_axi_bresp, s_axi_rresp, rr;
  logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, req_valid = 1'b0;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                  s_axi_rvalid, req_ready, rsp_valid, vm_active;
  v86pc_pkg::v86pc_req_s req = '0;
  v86pc_pkg::v86pc_rsp_s rsp, got;
  logic [3:0]            tss_t = 4'h0;
  int                    errors = 0, num_checks = 0;

  // The clock toggles every half period of 2 ns.
  always #2 ref_clk = ~ref_clk;

  v86pc_checks u_dut (
    .ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .req_valid, .req, .req_ready, .rsp_valid, .rsp, .vm_active
  );

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Address and data go out together; each is dropped at the edge that takes it.
  // Only the watchdog limits a wait; one idle edge follows so that bready is not
  // lowered and raised again in the same time step by the next call.
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d);
    s_axi_awaddr <= {27'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic axi_read(input logic [4:0] a);
    s_axi_araddr <= {27'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  // One request; the answer is sampled just after the edge that takes it.
  task automatic send(input v86pc_pkg::v86pc_op_e op, input logic [15:0] p,
                      input logic [2:0] sz, input logic [31:0] d, input logic cf);
    req <= '{op: op, port: p, size: sz, op32: 1'b1, data: d, gate_conf: cf, cr3: d,
             tss_type: tss_t,
             gate_sel: 16'h0038, seg: 16'h1234, offset: 16'h0010, default: '0};
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    got = rsp;
    check(rsp_valid, 1'b1);
    @(posedge ref_clk);
  endtask

  task automatic t_regs();
    axi_read(v86pc_pkg::OFF_CTRL);
    check(rd, v86pc_pkg::CTRL_RST);
    axi_read(v86pc_pkg::OFF_FLAGS);
    check(rd, v86pc_pkg::FLAGS_RST);
    axi_read(5'h1c);
    check(rr, v86pc_pkg::RESP_ERR);
  endtask

  task automatic t_priv();
    axi_write(v86pc_pkg::OFF_CTRL, 32'h0000_0001);
    send(v86pc_pkg::OP_PRIV, 16'h0, 3'h1, 32'h0, 1'b0);
    check(got.fault, 1'b0);
    axi_write(v86pc_pkg::OFF_CTRL, 32'h0);
    send(v86pc_pkg::OP_PMONLY, 16'h0, 3'h1, 32'h0, 1'b0);
    check({got.fault, got.vector}, {1'b1, v86pc_pkg::VEC_UD});
    axi_write(v86pc_pkg::OFF_CTRL, 32'h0000_000d);
    send(v86pc_pkg::OP_PRIV, 16'h0, 3'h1, 32'h0, 1'b0);
    check({got.fault, got.vector}, {1'b1, v86pc_pkg::VEC_GP});
    send(v86pc_pkg::OP_CLI, 16'h0, 3'h1, 32'h0, 1'b0);
    check(got.fault, 1'b1);
    send(v86pc_pkg::OP_STI, 16'h0, 3'h1, 32'h0, 1'b0);
    check(got.fault, 1'b1);
    axi_read(v86pc_pkg::OFF_FLAGS);
    check(rd, v86pc_pkg::FLAGS_RST);
    axi_read(v86pc_pkg::OFF_STATUS);
    check(rd, {16'h0000, 6'h00, 1'b0, 1'b1, v86pc_pkg::VEC_GP});
  endtask

  // Only bit 1 of the byte for ports 40 to 47 is set, so port 41 alone is refused.
  task automatic t_io();
    logic [15:0] pt [5] = '{16'd40, 16'd41, 16'd38, 16'd32, 16'hfff0};
    logic [2:0]  sz [5] = '{3'd1, 3'd1, 3'd4, 3'd4, 3'd1};
    logic        ft [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    // Byte 0x16 keeps its all-ones reset value and lies inside the 0x7f limit.
    axi_write(v86pc_pkg::OFF_IOMAP, 32'h007f_0010);
    axi_write(v86pc_pkg::OFF_TSSB, 32'h0015_0002);
    axi_write(v86pc_pkg::OFF_TSSB, 32'h0014_0000);
    for (int i = 0; i < 5; i++) begin
      send(v86pc_pkg::OP_IO, pt[i], sz[i], 32'h0, 1'b0);
      check(got.fault, ft[i]);
    end
    axi_write(v86pc_pkg::OFF_CTRL, 32'h0000_0001);
    send(v86pc_pkg::OP_IO, 16'd41, 3'd1, 32'h0, 1'b0);
    check(got.fault, 1'b0);
  endtask

  task automatic t_vm();
    send(v86pc_pkg::OP_IRET, 16'h0, 3'h1, 32'h0002_3002, 1'b0);
    check(vm_active, 1'b1);
    send(v86pc_pkg::OP_MEM, 16'h0, 3'h1, 32'h0, 1'b0);
    check(got.phys, 24'h01_2350);
    send(v86pc_pkg::OP_IO, 16'd41, 3'd1, 32'h0, 1'b0);
    check(got.fault, 1'b1);
    send(v86pc_pkg::OP_IO, 16'hfff0, 3'd1, 32'h0, 1'b0);
    check(got.fault, 1'b1);
    send(v86pc_pkg::OP_PUSHF, 16'h0, 3'h1, 32'h0, 1'b0);
    check(got.data[17], 1'b0);
    send(v86pc_pkg::OP_POPF, 16'h0, 3'h1, 32'h0000_3002, 1'b0);
    check(vm_active, 1'b1);
    send(v86pc_pkg::OP_PRIV, 16'h0, 3'h1, 32'h0, 1'b0);
    check({got.fault, got.vector}, {1'b1, v86pc_pkg::VEC_GP});
    send(v86pc_pkg::OP_EVENT, 16'h0, 3'h1, 32'h0, 1'b1);
    check({got.fault, got.err}, {1'b1, 16'h0038});
    send(v86pc_pkg::OP_EVENT, 16'h0, 3'h1, 32'h0, 1'b0);
    check({got.data[17], vm_active}, 2'b10);
    send(v86pc_pkg::OP_IRET, 16'h0, 3'h1, 32'h0002_0002, 1'b0);
    send(v86pc_pkg::OP_INTN, 16'h0, 3'h1, 32'h0, 1'b0);
    check(got.fault, 1'b1);
    send(v86pc_pkg::OP_INTU, 16'h0, 3'h1, 32'h0, 1'b0);
    check(got.fault, 1'b0);
  endtask

  // Switch into a full-format task in the mode, out to an old-format one, then page.
  task automatic t_tsw();
    tss_t = v86pc_pkg::TSS_FULL;
    send(v86pc_pkg::OP_TSWITCH, 16'h0, 3'h1, 32'h0002_0002, 1'b0);
    check({got.data[17], got.seg_8086, vm_active}, 3'b111);
    axi_read(v86pc_pkg::OFF_PDB);
    check(rd, 32'h0002_0002);
    tss_t = 4'h1;
    send(v86pc_pkg::OP_TSWITCH, 16'h0, 3'h1, 32'h0000_0002, 1'b0);
    check({got.seg_8086, vm_active}, 2'b00);
    axi_write(v86pc_pkg::OFF_CTRL, 32'h0000_0003);
    axi_write(v86pc_pkg::OFF_PAGE, 32'h000a_bc12);
    send(v86pc_pkg::OP_MEM, 16'h0, 3'h1, 32'h0, 1'b0);
    check(got.phys, 24'hab_c350);
  endtask

  // Reset for five cycles, then run every scenario in turn.
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs();
    t_priv();
    t_io();
    t_vm();
    t_tsw();
    final_report();
  end

  // The scenarios need well under a thousand cycles; a hang is cut off far beyond.
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    final_report();
  end
endmodule
